// ===== adsp_serial_port.sv
// Serial control port with conversion word FIFO and link clock crossing
`timescale 1ns/1ps
`include "adsp_regs.svh"

// What this block does
// [R1] Host waits about 20 ms after power-up before talking to the port; the host model waits STARTUP_NS, 200 ns.
// [R2] Host always brings the port to a known state; there is no power-on reset.
// [R3] Host resyncs with fifteen 0xFF fill bytes then one 0xFE terminate byte.
// [R4] Complete resync sequence returns the port to command mode from any state.
// [R5] Host performs system reset once the port is in command mode.
// [R6] Host then programs reference, word rate and polarity settings.
// [R7] Host starts calibrations or conversions only after resync, reset, configure.
// [R8] Shift clock is acted on only while select is low; reqSync still shifts on every rising edge.
// [R9] Serial output is driven only while select is low, else released.
// [R10] Host changes select only while the shift clock is low.
// [R11] One bit in and one bit out per shift-clock period.
// [R12] The two logic output pins follow their configuration bits.
// [R13] Polarity bit set means unipolar, cleared means bipolar.
// [R14] Conversion word is 32 bits, MSB first, result in the upper 24 bits.
// [R15] Overrange flag sits in bit 2; other low-byte bits read zero.
// [R16] Input sampled on rising edge, output changed on falling edge.

// ----------------------------------------------------------------
// Word FIFO, flip-flop storage
// ----------------------------------------------------------------
module adsp_word_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = `ADSP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic full;
    logic empty;
    logic ready;
  } adsp_fifo_s;

  adsp_fifo_s st;
  adsp_fifo_s next_st;
  logic push;
  logic pop;

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
    $error("adsp_word_fifo: DEPTH must be a power of two, at least 2");
  end

  assign push = inValid && !st.full;
  assign pop = outReady && !st.empty;
  // Ready is its own flop so the top's ready output comes straight from a register
  assign inReady = st.ready;
  assign outValid = !st.empty;
  assign outData = st.mem[st.rdPtr];

  // Next state: write, read and level
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
    next_st.full = (next_st.count == (AW + 1)'(DEPTH));
    next_st.empty = (next_st.count == '0);
    next_st.ready = !next_st.full;
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.empty <= 1'b1;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ----------------------------------------------------------------
// Top: serial port
// ----------------------------------------------------------------
module adsp_serial_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic shiftClk,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic cfgLogicOutLow,
  input wire logic cfgLogicOutHigh,
  input wire logic cfgUnipolar,
  output logic logicOutLow,
  output logic logicOutHigh,
  output logic unipolarMode,
  input wire logic convValid,
  output logic convReady,
  input wire adsp_pkg::adsp_conv_s convData,
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic resyncStrobe
);
  adsp_pkg::adsp_sys_s sy;
  adsp_pkg::adsp_sys_s next_sy;
  adsp_pkg::adsp_link_s lk;
  adsp_pkg::adsp_link_s next_lk;
  adsp_pkg::adsp_conv_s headData;
  logic headValid;
  logic headTake;
  logic txBusy;
  logic [7:0] byteDone;
  logic outBit;

  // Builds the outgoing word; status bits other than overrange stay zero
  function automatic logic [31:0] buildWord(input adsp_pkg::adsp_conv_s c);
    logic [31:0] w;
    w = '0;
    w[31 -: `ADSP_RESULT_BITS] = c.result;
    // [R15] overrange bit only
    w[`ADSP_OVERRANGE_BIT] = c.overrangeFlag;
    return w;
  endfunction

  adsp_word_fifo #(
    .WIDTH($bits(adsp_pkg::adsp_conv_s)),
    .DEPTH(`ADSP_FIFO_DEPTH)
  ) uFifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(convValid),
    .inReady(convReady),
    .inData(convData),
    .outValid(headValid),
    .outReady(headTake),
    .outData(headData)
  );

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  // A word is pending until the link's acknowledge toggle matches the request
  assign txBusy = (sy.reqTgl != sy.ackSync[1]);
  assign headTake = !txBusy;

  always_comb begin
    next_sy = sy;
    next_sy.rxSync = {sy.rxSync[0], lk.rxTgl};
    next_sy.rxSeen = sy.rxSync[1];
    next_sy.resSync = {sy.resSync[0], lk.resyncTgl};
    next_sy.resSeen = sy.resSync[1];
    next_sy.ackSync = {sy.ackSync[0], lk.ackTgl};
    // [R12] mirror logic bits
    next_sy.logicOutLow = cfgLogicOutLow;
    next_sy.logicOutHigh = cfgLogicOutHigh;
    // [R13] polarity select
    next_sy.unipolarMode = cfgUnipolar;
    // Received byte is stable for eight shift clocks, ample to copy here
    next_sy.rxStrobe = (sy.rxSync[1] != sy.rxSeen);
    if (sy.rxSync[1] != sy.rxSeen) begin
      next_sy.rxByte = lk.rxByte;
    end
    next_sy.resyncStrobe = (sy.resSync[1] != sy.resSeen);
    // [R14] word assembly
    if (headValid && !txBusy) begin
      next_sy.txWord = buildWord(headData);
      next_sy.reqTgl = !sy.reqTgl;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  assign logicOutLow = sy.logicOutLow;
  assign logicOutHigh = sy.logicOutHigh;
  assign unipolarMode = sy.unipolarMode;
  assign rxByte = sy.rxByte;
  assign rxStrobe = sy.rxStrobe;
  assign resyncStrobe = sy.resyncStrobe;

  // ----------------------------------------------------------------
  // Link domain, rising shift-clock edge
  // ----------------------------------------------------------------
  assign byteDone = {lk.shiftIn[6:0], serialIn};

  always_comb begin
    next_lk = lk;
    next_lk.reqSync = {lk.reqSync[0], sy.reqTgl};
    // [R8] [R10] select gates every edge except the reqSync stage, which shifts on every rise
    if (!selectN) begin
      // [R11] [R16] sample input on rise
      next_lk.shiftIn = byteDone;
      next_lk.bitCnt = lk.bitCnt + 1'b1;
      if (lk.state == adsp_pkg::LINK_READ) begin
        next_lk.txShift = {lk.txShift[30:0], 1'b0};
        next_lk.txCnt = lk.txCnt + 1'b1;
        if (lk.txCnt == `ADSP_LAST_BIT_CNT) begin
          next_lk.state = adsp_pkg::LINK_CMD;
          next_lk.ackTgl = !lk.ackTgl;
        end
      end
      if (lk.bitCnt == 3'h7) begin
        // [R4] resync from any state
        if (byteDone == `ADSP_SYNC_FILL_CMD) begin
          if (lk.fillCnt != `ADSP_SYNC_FILL_COUNT) begin
            next_lk.fillCnt = lk.fillCnt + 1'b1;
          end
        end else if (byteDone == `ADSP_SYNC_TERM_CMD
                     && lk.fillCnt == `ADSP_SYNC_FILL_COUNT) begin
          next_lk.fillCnt = '0;
          next_lk.state = adsp_pkg::LINK_CMD;
          next_lk.txCnt = '0;
          next_lk.resyncTgl = !lk.resyncTgl;
        end else begin
          next_lk.fillCnt = '0;
        end
        if (lk.state == adsp_pkg::LINK_CMD) begin
          next_lk.rxByte = byteDone;
          next_lk.rxTgl = !lk.rxTgl;
          // Read starts only if a word is waiting; otherwise stays in command mode
          if (byteDone == `ADSP_READ_CMD && lk.reqSync[1] != lk.ackTgl) begin
            next_lk.state = adsp_pkg::LINK_READ;
            next_lk.txShift = sy.txWord;
            next_lk.txCnt = '0;
          end
        end
      end
    end
  end

  always_ff @(posedge shiftClk or negedge arst_n) begin
    if (!arst_n) begin
      lk <= '0;
      lk.state <= adsp_pkg::LINK_CMD;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // Link domain, falling shift-clock edge
  // ----------------------------------------------------------------
  // [R16] output changes on fall
  always_ff @(negedge shiftClk or negedge arst_n) begin
    if (!arst_n) begin
      outBit <= 1'b0;
    end else if (!selectN) begin
      outBit <= (lk.state == adsp_pkg::LINK_READ) ? lk.txShift[31] : 1'b0;
    end
  end

  assign serialOut = outBit;
  // [R9] release output while deselected; must follow select with no clock
  assign serialOutEn = !selectN;
endmodule

// ===== adsp_regs.svh
// Constants of the serial control port: command codes, word layout and counts
`ifndef ADSP_REGS_SVH
`define ADSP_REGS_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define ADSP_SYNC_FILL_CMD 8'hFF
`define ADSP_SYNC_TERM_CMD 8'hFE
`define ADSP_READ_CMD 8'h0C
`define ADSP_SYNC_FILL_COUNT 4'hF

// ----------------------------------------------------------------
// Conversion word layout
// ----------------------------------------------------------------
`define ADSP_WORD_BITS 32
`define ADSP_RESULT_BITS 24
`define ADSP_OVERRANGE_BIT 2
`define ADSP_LAST_BIT_CNT 5'h1F
`define ADSP_FIFO_DEPTH 32

`endif

// ===== adsp_pkg.sv
// Types shared by the serial control port
package adsp_pkg;

  // ----------------------------------------------------------------
  // Data carried through the port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] result;
    logic overrangeFlag;
  } adsp_conv_s;

  typedef enum logic [1:0] {
    LINK_CMD = 2'b01,
    LINK_READ = 2'b10
  } adsp_link_e;

  // ----------------------------------------------------------------
  // State of the link side, rising shift-clock edge
  // ----------------------------------------------------------------
  typedef struct packed {
    adsp_link_e state;
    logic [7:0] shiftIn;
    logic [2:0] bitCnt;
    logic [3:0] fillCnt;
    logic [7:0] rxByte;
    logic rxTgl;
    logic resyncTgl;
    logic [1:0] reqSync;
    logic ackTgl;
    logic [31:0] txShift;
    logic [4:0] txCnt;
  } adsp_link_s;

  // ----------------------------------------------------------------
  // State of the system side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rxSync;
    logic rxSeen;
    logic [1:0] resSync;
    logic resSeen;
    logic [1:0] ackSync;
    logic reqTgl;
    logic [31:0] txWord;
    logic logicOutLow;
    logic logicOutHigh;
    logic unipolarMode;
    logic [7:0] rxByte;
    logic rxStrobe;
    logic resyncStrobe;
  } adsp_sys_s;

endpackage

// ===== adsp_serial_port_monitor.sv
// Checker of the serial port pins
`timescale 1ns/1ps
`include "adsp_regs.svh"
module adsp_serial_port_monitor (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic shiftClk,
  input wire logic selectN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic cfgLogicOutLow,
  input wire logic cfgLogicOutHigh,
  input wire logic cfgUnipolar,
  input wire logic logicOutLow,
  input wire logic logicOutHigh,
  input wire logic unipolarMode,
  input wire logic [7:0] rxByte,
  input wire logic rxStrobe,
  input wire logic resyncStrobe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ----------
  // Pin rules
  // ----------
  // Output gating
  a_oe_select: assert property (serialOutEn == !selectN)
    else $error("enable differs from select");
  a_low_mirror: assert property (logicOutLow == $past(cfgLogicOutLow))
    else $error("low pin not mirrored");
  a_high_mirror: assert property ($changed(cfgLogicOutHigh) |=>
    logicOutHigh == $past(cfgLogicOutHigh)) else $error("high pin not mirrored");
  a_mode_mirror: assert property (unipolarMode == $past(cfgUnipolar))
    else $error("polarity not mirrored");
  a_resync_single: assert property (resyncStrobe |=> !resyncStrobe)
    else $error("resync pulse too long");
  a_rx_single: assert property (rxStrobe |=> !rxStrobe)
    else $error("byte pulse too long");
  a_byte_strobe: assert property ($changed(rxByte) |-> rxStrobe)
    else $error("byte changed without pulse");
  a_out_fall: assert property ($changed(serialOut) |-> !shiftClk && !selectN)
    else $error("output moved off a selected fall");
  c_resync: cover property (resyncStrobe);
  c_read: cover property (rxStrobe && rxByte == `ADSP_READ_CMD);
  c_out: cover property ($rose(serialOut));
endmodule
bind adsp_serial_port adsp_serial_port_monitor adsp_serial_port_monitor_inst (.clk_sys,
  .arst_n, .shiftClk, .selectN, .serialOut, .serialOutEn, .cfgLogicOutLow,
  .cfgLogicOutHigh, .cfgUnipolar, .logicOutLow, .logicOutHigh, .unipolarMode,
  .rxByte, .rxStrobe, .resyncStrobe);

// ===== adsp_host_model.sv
// Host model driving the four-wire port
`timescale 1ns/1ps
`include "adsp_regs.svh"
module adsp_host_model #(
  parameter int STARTUP_NS = 200
) (
  output logic shiftClk,
  output logic selectN,
  output logic serialIn,
  input wire logic serialOut
);
  bit awake = 1'b0;
  initial begin
    shiftClk = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
  end
  // ----------
  // Frames
  // ----------
  // Select moves with clock low
  task automatic frame(input logic [31:0] tx, input int n, input bit skipSel,
                       output logic [31:0] rx);
    rx = 32'h0;
    if (!awake) #(STARTUP_NS);
    awake = 1'b1;
    #1 selectN = skipSel; // Odd offset keeps link edges off system edges only for a frame that starts on an even time
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = tx[i];
      #6 shiftClk = 1'b1;
      rx[i] = serialOut;
      #6 shiftClk = 1'b0;
    end
    #6 selectN = 1'b1;
    serialIn = ~serialIn; // Idle line never shows stale data
  endtask
  task automatic resync();
    logic [31:0] rx;
    repeat (15) frame(`ADSP_SYNC_FILL_CMD, 8, 1'b0, rx);
    frame(`ADSP_SYNC_TERM_CMD, 8, 1'b0, rx);
  endtask
endmodule

// ===== adsp_serial_port_bench.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`include "adsp_regs.svh"
module adsp_serial_port_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic shiftClk, selectN, serialIn, serialOut, serialOutEn;
  logic [2:0] cfg = 3'h0;
  logic logicOutLow, logicOutHigh, unipolarMode, convReady, rxStrobe, resyncStrobe;
  logic convValid = 1'b0;
  adsp_pkg::adsp_conv_s convData = '0;
  adsp_pkg::adsp_conv_s q[$];
  logic [7:0] rxByte, lastRx, b;
  logic [31:0] rx;
  bit taken;
  int seed = 88, n_fail = 0, check_count = 0, rxCnt = 0, resCnt = 0, cycles = 0, rxBase = 0;
  always #2 clk_sys = ~clk_sys;
  adsp_serial_port adsp_serial_port_inst (.clk_sys, .arst_n, .shiftClk, .selectN,
    .serialIn, .serialOut, .serialOutEn, .cfgLogicOutLow(cfg[2]),
    .cfgLogicOutHigh(cfg[1]), .cfgUnipolar(cfg[0]), .logicOutLow, .logicOutHigh,
    .unipolarMode, .convValid, .convReady, .convData, .rxByte, .rxStrobe, .resyncStrobe);
  adsp_host_model adsp_host_model_inst (.shiftClk, .selectN, .serialIn, .serialOut);
  // Pulses last one cycle, so count them where they land
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (rxStrobe === 1'b1) begin
      rxCnt <= rxCnt + 1;
      lastRx <= rxByte;
    end
    if (resyncStrobe === 1'b1) resCnt <= resCnt + 1;
    if (cycles == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] expWord(input adsp_pkg::adsp_conv_s c);
    return {c.result, 5'h00, c.overrangeFlag, 2'h0};
  endfunction
  task automatic sendByte(input logic [7:0] v, input bit skipSel);
    adsp_host_model_inst.frame({24'h000000, v}, 8, skipSel, rx);
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic readWord(output logic [31:0] w);
    sendByte(`ADSP_READ_CMD, 1'b0);
    adsp_host_model_inst.frame(32'h0, 32, 1'b0, w);
    repeat (12) @(posedge clk_sys);
  endtask
  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    adsp_host_model_inst.resync();
    repeat (12) @(posedge clk_sys);
    check(32'(resCnt), 32'h1);
    check(32'(serialOutEn), 32'h0);
    // System reset once in command mode
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    check(32'(rxByte), 32'h0);
    check(32'(convReady), 32'h1);
    repeat (16) begin
      b = 8'($random(seed));
      @(posedge clk_sys);
      cfg <= b[2:0];
      @(posedge clk_sys);
      @(negedge clk_sys);
      check({logicOutLow, logicOutHigh, unipolarMode}, b[2:0]);
    end
    // Deselected clocks do nothing; resync bytes were forwarded too
    rxBase = rxCnt;
    for (int i = 0; i < 6; i++) begin
      b = {1'b0, 7'($random(seed))};
      if (b == `ADSP_READ_CMD) b = 8'h5A;
      sendByte(~b, 1'b1);
      sendByte(b, 1'b0);
      check(32'(rxCnt - rxBase), 32'(i + 1));
      check(32'(lastRx), 32'(b));
    end
    // Fill until refused, corner word first
    @(posedge clk_sys);
    convData <= '{24'hFFFFFF, 1'b1};
    convValid <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      taken = convReady === 1'b1;
      if (taken) q.push_back(convData);
      @(posedge clk_sys);
      if (taken) convData <= 25'($random(seed));
    end
    convValid <= 1'b0;
    // Thirty-two words in the FIFO plus one already held for the link
    check(32'(q.size()), 32'h21);
    // Resync during a read; the fill clocks finish the word in flight
    sendByte(`ADSP_READ_CMD, 1'b0);
    adsp_host_model_inst.frame(32'h0, 16, 1'b0, rx);
    check(rx, expWord(q[0]) >> 16);
    adsp_host_model_inst.resync();
    repeat (12) @(posedge clk_sys);
    check(32'(resCnt), 32'h2);
    // Sixteen read bits plus sixteen fill clocks complete the first word
    void'(q.pop_front());
    // Drain in order while the host stalls
    while (q.size() > 0) begin
      readWord(rx);
      check(rx, expWord(q.pop_front()));
    end
    check(32'(convReady), 32'h1);
    give_verdict();
  end
endmodule
